// ===== gsipo_map.svh
// constants for the gated serial-in parallel-out shifter
`ifndef GSIPO_MAP_SVH
`define GSIPO_MAP_SVH

// stage count and buffer depth
`define GSIPO_STAGES      8
`define GSIPO_FIFO_DEPTH  8
`define GSIPO_FIFO_WIDTH  1

// reset value of the stage register
`define GSIPO_STAGE_RST   8'h00

// pin synchroniser order: bit 0 shift clock, 1 clear, 2 serial a, 3 serial b
`define GSIPO_PIN_CLK     0
`define GSIPO_PIN_CLR     1
`define GSIPO_PIN_A       2
`define GSIPO_PIN_B       3
`define GSIPO_PINS        4
// clock resets high so a first edge needs a low first; clear reads as active
`define GSIPO_PIN_RST     4'h1

`endif

// ===== gsipo_pkg.sv
// types of the gated serial-in parallel-out shifter
`include "gsipo_map.svh"

package gsipo_pkg;
    typedef logic [`GSIPO_STAGES-1:0] gsipo_stage_t;
    typedef logic [`GSIPO_PINS-1:0]   gsipo_pins_t;
endpackage

// ===== gsipo_fifo.sv
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "gsipo_map.svh"

module gsipo_fifo #(
    parameter int WIDTH = `GSIPO_FIFO_WIDTH,
    parameter int DEPTH = `GSIPO_FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [CW-1:0]    count_r;
    logic             full_r;
    logic [CW-1:0]    count_nxt;
    logic             doPush;
    logic             doPop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    // handshakes and occupancy
    assign inReady   = !full_r;
    assign outValid  = (count_r != '0);
    assign outData   = mem[rdPtr_r];
    assign doPush    = inValid && inReady;
    assign doPop     = outValid && outReady;
    assign count_nxt = count_r + CW'(doPush) - CW'(doPop);

    // pointers and count, flush empties at once
    always_ff @(posedge clk_sys) begin
        if (rst || flush) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
            full_r  <= 1'b0;
        end else begin
            if (doPush) wrPtr_r <= bump(wrPtr_r);
            if (doPop) rdPtr_r <= bump(rdPtr_r);
            count_r <= count_nxt;
            full_r  <= (count_nxt == CW'(DEPTH));
        end
    end

    // storage
    always_ff @(posedge clk_sys) begin
        if (doPush) mem[wrPtr_r] <= inData;
    end
endmodule

// ===== gsipo_shifter.sv
// eight-stage shifter with gated serial entry, parallel outputs and clear
`timescale 1ns/1ps
`include "gsipo_map.svh"

// How it works
// - eight stages are held and each one shows on its own parallel output all the time.
// - each rising shift clock edge that finds room in the buffer moves every stage one place up and drops the last one.
// - on that edge the first stage takes the AND of both serial inputs as they were before.
// - either serial input gates the other, so a low on either loads zero and both high a one.
// - a low master clear zeroes all stages without waiting for any shift clock edge.
// - while clear is low it beats the clock and both serial inputs, so all stages stay zero.
module gsipo_shifter (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               shift_clock,
    input  wire logic               master_clear_n,
    input  wire logic               serialInA,
    input  wire logic               serialInB,
    input  wire logic               shiftHold,
    output gsipo_pkg::gsipo_stage_t stageOutputs,
    output logic                    captureReady,
    output logic                    loadOverflow
);
    gsipo_pkg::gsipo_pins_t  pinRaw;
    gsipo_pkg::gsipo_pins_t  sync1_r;
    gsipo_pkg::gsipo_pins_t  sync2_r;
    gsipo_pkg::gsipo_pins_t  sync3_r;
    gsipo_pkg::gsipo_pins_t  stable_r;
    gsipo_pkg::gsipo_pins_t  stable_nxt;
    gsipo_pkg::gsipo_stage_t stage_r;
    gsipo_pkg::gsipo_stage_t stage_nxt;
    logic                    clearActive;
    logic                    clkRise;
    logic                    pushBit;
    logic                    pushValid;
    logic                    fifoInReady;
    logic                    popValid;
    logic                    popBit;
    logic                    popTake;
    logic                    overflow_r;
    logic                    captureReady_r;

    // gated entry bit: either input enables the other
    function automatic logic gateBit(input logic a, input logic b);
        gateBit = a & b;
    endfunction

    // a pin change counts once the second and third stages agree
    function automatic gsipo_pkg::gsipo_pins_t settle(
        input gsipo_pkg::gsipo_pins_t s2,
        input gsipo_pkg::gsipo_pins_t s3,
        input gsipo_pkg::gsipo_pins_t old
    );
        settle = (s2 & s3) | (old & (s2 ^ s3));
    endfunction

    // pins gathered into one vector
    assign pinRaw[`GSIPO_PIN_CLK] = shift_clock;
    assign pinRaw[`GSIPO_PIN_CLR] = master_clear_n;
    assign pinRaw[`GSIPO_PIN_A]   = serialInA;
    assign pinRaw[`GSIPO_PIN_B]   = serialInB;

    // three-stage pin synchroniser
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_r <= `GSIPO_PIN_RST;
            sync2_r <= `GSIPO_PIN_RST;
            sync3_r <= `GSIPO_PIN_RST;
        end else begin
            sync1_r <= pinRaw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // settled pin levels
    assign stable_nxt = settle(sync2_r, sync3_r, stable_r);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stable_r <= `GSIPO_PIN_RST;
        end else begin
            stable_r <= stable_nxt;
        end
    end

    // clear level, shift edge and the bit that enters
    assign clearActive = !stable_r[`GSIPO_PIN_CLR];
    assign clkRise     = stable_nxt[`GSIPO_PIN_CLK] && !stable_r[`GSIPO_PIN_CLK];
    // data as it stood before the edge, not the value that settles with it
    assign pushBit     = gateBit(stable_r[`GSIPO_PIN_A], stable_r[`GSIPO_PIN_B]);
    assign pushValid   = clkRise && !clearActive;

    // edges wait here when the stage register is held
    gsipo_fifo #(
        .WIDTH (`GSIPO_FIFO_WIDTH),
        .DEPTH (`GSIPO_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .flush    (clearActive),
        .inValid  (pushValid),
        .inReady  (fifoInReady),
        .inData   (pushBit),
        .outValid (popValid),
        .outReady (popTake),
        .outData  (popBit)
    );

    // one queued edge shifts per cycle unless held or cleared
    assign popTake = !shiftHold && !clearActive;

    // next stage value: clear first, then shift, else keep
    always_comb begin
        stage_nxt = stage_r;
        if (clearActive) begin
            stage_nxt = `GSIPO_STAGE_RST;
        end else if (popValid && popTake) begin
            stage_nxt = {stage_r[`GSIPO_STAGES-2:0], popBit};
        end
    end

    // stage register drives the parallel outputs directly
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage_r <= `GSIPO_STAGE_RST;
        end else begin
            stage_r <= stage_nxt;
        end
    end

    // status: edges lost while full, and room for the next edge
    always_ff @(posedge clk_sys) begin
        if (rst || clearActive) begin
            overflow_r     <= 1'b0;
            captureReady_r <= 1'b0;
        end else begin
            overflow_r     <= overflow_r || (pushValid && !fifoInReady);
            captureReady_r <= fifoInReady;
        end
    end

    assign stageOutputs = stage_r;
    assign captureReady = captureReady_r;
    assign loadOverflow = overflow_r;

    // shadow count of queued edges, kept apart from the buffer for the checks
    logic [3:0] shadowCount_r;
    logic [3:0] shadowCount_nxt;
    logic       shadowIn;
    logic       shadowOut;

    assign shadowIn        = pushValid && fifoInReady;
    assign shadowOut       = popValid && popTake;
    assign shadowCount_nxt = shadowCount_r + 4'(shadowIn) - 4'(shadowOut);

    // count follows accepted and taken edges, emptied by clear
    always_ff @(posedge clk_sys) begin
        if (rst || clearActive) begin
            shadowCount_r <= 4'h0;
        end else begin
            shadowCount_r <= shadowCount_nxt;
        end
    end

    // checks on the stage path
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_clear_zeroes: assert property (clearActive |=> stage_r == `GSIPO_STAGE_RST)
        else $error("stages not zero after clear");

    a_clear_pin_latency: assert property ((!master_clear_n) [*5] |=> stage_r == 8'h00)
        else $error("clear pin did not zero stages in time");

    a_clear_blocks_load: assert property (clearActive |-> !pushValid && !popTake)
        else $error("load accepted during clear");

    a_shift_moves_up: assert property (popValid && popTake
        |=> stage_r[`GSIPO_STAGES-1:1] == $past(stage_r[`GSIPO_STAGES-2:0]))
        else $error("stages did not move up");

    a_first_stage_load: assert property (popValid && popTake |=> stage_r[0] == $past(popBit))
        else $error("first stage took wrong bit");

    a_gate_low_zero: assert property (clkRise && !(stable_r[`GSIPO_PIN_A]
        && stable_r[`GSIPO_PIN_B]) |-> !pushBit)
        else $error("gated low input loaded a one");

    a_gate_both_high: assert property (pushValid && stable_r[`GSIPO_PIN_A]
        && stable_r[`GSIPO_PIN_B] && fifoInReady |=> popValid)
        else $error("accepted edge not queued");

    a_idle_holds: assert property (!clearActive && !(popValid && popTake)
        |=> stage_r == $past(stage_r))
        else $error("stages changed without an edge");

    a_edge_queued: assert property (clkRise && !clearActive |-> pushValid)
        else $error("rising edge ignored");

    a_output_follows: assert property (##1 stageOutputs == stage_r)
        else $error("outputs differ from stages");

    // synchroniser and settling checks
    a_sync_second: assert property (1'b1 |=> sync2_r == $past(sync1_r))
        else $error("second synchroniser stage lags");

    a_sync_third: assert property (1'b1 |=> sync3_r == $past(sync2_r))
        else $error("third synchroniser stage lags");

    a_clk_settle: assert property (
        sync2_r[`GSIPO_PIN_CLK] == sync3_r[`GSIPO_PIN_CLK]
        |=> stable_r[`GSIPO_PIN_CLK] == $past(sync3_r[`GSIPO_PIN_CLK]))
        else $error("settled clock missed agreeing stages");

    a_clk_keep: assert property (
        sync2_r[`GSIPO_PIN_CLK] != sync3_r[`GSIPO_PIN_CLK]
        |=> stable_r[`GSIPO_PIN_CLK] == $past(stable_r[`GSIPO_PIN_CLK]))
        else $error("settled clock moved on disagreeing stages");

    a_clr_settle: assert property (
        sync2_r[`GSIPO_PIN_CLR] == sync3_r[`GSIPO_PIN_CLR]
        |=> stable_r[`GSIPO_PIN_CLR] == $past(sync3_r[`GSIPO_PIN_CLR]))
        else $error("settled clear missed agreeing stages");

    a_clr_keep: assert property (
        sync2_r[`GSIPO_PIN_CLR] != sync3_r[`GSIPO_PIN_CLR]
        |=> stable_r[`GSIPO_PIN_CLR] == $past(stable_r[`GSIPO_PIN_CLR]))
        else $error("settled clear moved on disagreeing stages");

    a_sera_settle: assert property (
        sync2_r[`GSIPO_PIN_A] == sync3_r[`GSIPO_PIN_A]
        |=> stable_r[`GSIPO_PIN_A] == $past(sync3_r[`GSIPO_PIN_A]))
        else $error("settled input a missed agreeing stages");

    a_sera_keep: assert property (
        sync2_r[`GSIPO_PIN_A] != sync3_r[`GSIPO_PIN_A]
        |=> stable_r[`GSIPO_PIN_A] == $past(stable_r[`GSIPO_PIN_A]))
        else $error("settled input a moved on disagreeing stages");

    a_serb_settle: assert property (
        sync2_r[`GSIPO_PIN_B] == sync3_r[`GSIPO_PIN_B]
        |=> stable_r[`GSIPO_PIN_B] == $past(sync3_r[`GSIPO_PIN_B]))
        else $error("settled input b missed agreeing stages");

    a_serb_keep: assert property (
        sync2_r[`GSIPO_PIN_B] != sync3_r[`GSIPO_PIN_B]
        |=> stable_r[`GSIPO_PIN_B] == $past(stable_r[`GSIPO_PIN_B]))
        else $error("settled input b moved on disagreeing stages");

    // edge detect and entry bit checks
    a_rise_after_low: assert property (clkRise |-> !stable_r[`GSIPO_PIN_CLK])
        else $error("edge seen without a low clock first");

    a_single_push: assert property (pushValid |=> !pushValid)
        else $error("one clock rise pushed twice");

    a_push_and: assert property (pushValid |-> pushBit == gateBit(stable_r[2], stable_r[3]))
        else $error("pushed bit is not the gated pair");

    a_one_needs_both: assert property (pushValid && pushBit |-> stable_r[2] && stable_r[3])
        else $error("one entered without both inputs high");

    a_clear_no_push: assert property (clearActive |-> !pushValid)
        else $error("edge pushed during clear");

    // queue and stage checks
    a_queue_empty: assert property (popValid == (shadowCount_r != 4'h0))
        else $error("queue valid disagrees with its count");

    a_queue_full: assert property (fifoInReady == (shadowCount_r != 4'(`GSIPO_FIFO_DEPTH)))
        else $error("queue ready disagrees with its count");

    a_queue_bound: assert property (shadowCount_r <= 4'(`GSIPO_FIFO_DEPTH))
        else $error("queue count beyond its depth");

    a_hold_keeps: assert property (shiftHold && !clearActive |=> stage_r == $past(stage_r))
        else $error("stages moved while held");

    a_empty_keeps: assert property (!popValid && !clearActive |=> stage_r == $past(stage_r))
        else $error("stages moved with an empty queue");

    a_zero_enters: assert property (popValid && popTake && !popBit |=> !stage_r[0])
        else $error("first stage not zero after a zero bit");

    a_last_stage: assert property (popValid && popTake |=> stage_r[7] == $past(stage_r[6]))
        else $error("last stage did not take the one below");

    // status and clear checks
    a_lost_edge: assert property (pushValid && !fifoInReady |=> overflow_r)
        else $error("lost edge did not set overflow");

    a_overflow_sticky: assert property (overflow_r && !clearActive |=> overflow_r)
        else $error("overflow dropped without clear");

    a_overflow_cause: assert property (
        !overflow_r && !(pushValid && !fifoInReady) |=> !overflow_r)
        else $error("overflow set without a lost edge");

    a_ready_copy: assert property (!clearActive |=> captureReady_r == $past(fifoInReady))
        else $error("ready is not last cycle's room");

    a_clear_status: assert property (clearActive |=> !overflow_r && !captureReady_r)
        else $error("status not cleared by clear");

    a_clear_keeps: assert property (clearActive && stage_r == 8'h00 |=> stage_r == 8'h00)
        else $error("stages left zero while clear held");

    a_clear_flush: assert property (clearActive |=> shadowCount_r == 4'h0 && !popValid)
        else $error("queue not emptied by clear");

    a_status_regs: assert property (loadOverflow == overflow_r && captureReady == captureReady_r)
        else $error("status outputs differ from their flops");

    c_shift_one: cover property (pushValid && pushBit ##[1:4] stage_r[0]);
    c_hold_fill: cover property (shiftHold && !fifoInReady);
    c_overflow: cover property ($rose(overflow_r));
    c_clear_data: cover property (stage_r != 8'h00 ##1 clearActive);
endmodule

// ===== gsipo_upstream.sv
// upstream model driving serial data, shift clock and clear
`timescale 1ns/1ps

module gsipo_upstream (
    input  wire logic clk_sys,
    output logic      shift_clock,
    output logic      master_clear_n,
    output logic      serialInA,
    output logic      serialInB
);
    // idle levels: clock low, clear off, unused serial inputs high
    initial begin
        shift_clock    = 1'b0;
        master_clear_n = 1'b1;
        serialInA      = 1'b1;
        serialInB      = 1'b1;
    end

    // wait some system clock edges
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // one shift clock pulse, data set up before and held after the rise
    task automatic send_bit(input logic a, input logic b);
        serialInA <= a;
        serialInB <= b;
        ticks(3);
        shift_clock <= 1'b1;
        ticks(3);
        shift_clock <= 1'b0;
        ticks(3);
    endtask

    // clear held low while the shift clock keeps toggling
    task automatic clear_run(input int n);
        master_clear_n <= 1'b0;
        repeat (n) begin
            ticks(3);
            shift_clock <= ~shift_clock;
        end
        ticks(3);
        master_clear_n <= 1'b1;
    endtask
endmodule

// ===== gsipo_shifter_tb.sv
// testbench of the gated serial-in parallel-out shifter
`timescale 1ns/1ps

module gsipo_shifter_tb;
    logic                    clk_sys;
    logic                    rst;
    logic                    shiftHold;
    logic                    shift_clock;
    logic                    master_clear_n;
    logic                    serialInA;
    logic                    serialInB;
    logic                    captureReady;
    logic                    loadOverflow;
    gsipo_pkg::gsipo_stage_t stageOutputs;
    gsipo_pkg::gsipo_stage_t expStage;
    int                      mismatches;
    int                      n_compared;

    gsipo_shifter u_gsipo_shifter (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .shift_clock    (shift_clock),
        .master_clear_n (master_clear_n),
        .serialInA      (serialInA),
        .serialInB      (serialInB),
        .shiftHold      (shiftHold),
        .stageOutputs   (stageOutputs),
        .captureReady   (captureReady),
        .loadOverflow   (loadOverflow)
    );

    gsipo_upstream u_gsipo_upstream (
        .clk_sys        (clk_sys),
        .shift_clock    (shift_clock),
        .master_clear_n (master_clear_n),
        .serialInA      (serialInA),
        .serialInB      (serialInB)
    );

    // 50 ns system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // compare helpers and settled-sample wait
    task automatic chk_stage(input string what, input gsipo_pkg::gsipo_stage_t e,
                             input gsipo_pkg::gsipo_stage_t g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_flag(input string what, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // shift one bit in and follow it in the expected stages
    task automatic send(input logic a, input logic b);
        @(posedge clk_sys);
        u_gsipo_upstream.send_bit(a, b);
        expStage = {expStage[6:0], a & b};
        settle(4);
        chk_stage("stages", expStage, stageOutputs);
    endtask

    // verdict
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        wrap_up;
    end

    // main sequence
    initial begin
        rst = 1'b1;
        shiftHold = 1'b0;
        expStage = 8'h00;
        mismatches = 0;
        n_compared = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        settle(10);
        chk_stage("stages", 8'h00, stageOutputs);
        chk_flag("ready", 1'b1, captureReady);
        $display("test reset done");
        // all four gate combinations
        for (int i = 0; i < 4; i++) begin
            send(i[1], i[0]);
        end
        $display("test gate done");
        // nine bits so the oldest falls out of the last stage
        for (int i = 8; i >= 0; i--) begin
            send(1'(9'h14b >> i), 1'b1);
        end
        $display("test fill done");
        settle(20);
        chk_stage("stages", expStage, stageOutputs);
        $display("test hold done");
        @(posedge clk_sys);
        fork
            u_gsipo_upstream.clear_run(8);
            begin
                settle(6);
                chk_stage("stages", 8'h00, stageOutputs);
            end
        join
        settle(10);
        chk_stage("stages", 8'h00, stageOutputs);
        expStage = 8'h00;
        $display("test clear done");
        // queue nine edges under hold: eight fit, one is lost
        @(posedge clk_sys);
        shiftHold <= 1'b1;
        repeat (9) u_gsipo_upstream.send_bit(1'b1, 1'b1);
        settle(6);
        chk_stage("stages", 8'h00, stageOutputs);
        chk_flag("ready", 1'b0, captureReady);
        chk_flag("overflow", 1'b1, loadOverflow);
        @(posedge clk_sys);
        shiftHold <= 1'b0;
        settle(12);
        chk_stage("stages", 8'hff, stageOutputs);
        @(posedge clk_sys);
        u_gsipo_upstream.clear_run(0);
        settle(10);
        chk_flag("overflow", 1'b0, loadOverflow);
        chk_stage("stages", 8'h00, stageOutputs);
        $display("test buffer done");
        wrap_up;
    end
endmodule
